// *** pic_ctrl.sv ***
// priority interrupt controller: sorting, nesting and dispatch
`timescale 1ns/10ps

module pic_ctrl import pic_pkg::*; (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire pic_cfg_type cfg,
	input wire pic_req_type requests,
	input wire logic global_enable_state,
	input wire logic nmi_pin,
	input wire logic watchdog_overflow_request,
	input wire logic cpu_ready,
	input wire logic [15:0] cur_pc,
	input wire logic [15:0] cur_psw,
	input wire logic break_instruction,
	input wire logic break_with_bank_switch,
	input wire logic [2:0] break_bank,
	input wire logic bank_switch_return,
	input wire logic [2:0] active_bank,
	input wire logic [15:0] return_immediate,
	input wire logic vectored_return,
	input wire pic_bank_wr_type bank_wr,
	output pic_dispatch_type dispatch,
	output logic [14:0] flag_clear,
	output logic [7:0] in_service
);

	// ==========================================================
	// helpers

	// level of the highest-priority entry in service, idle if none
	function automatic logic [3:0] top_level(input logic [7:0] isr);
		logic [3:0] r;
		r = LEVEL_IDLE;
		for (int k = 7; k >= 0; k--) begin
			if (isr[k]) begin
				r = 4'(k);
			end
		end
		return r;
	endfunction

	// software level of a maskable source via its group
	function automatic logic [2:0] src_level(input pic_cfg_type c,
			input int i);
		return c.group_level[GROUP_OF[i]];
	endfunction

	// ==========================================================
	// state
	pic_dispatch_type dispatch_ff;
	pic_dispatch_type nxt_dispatch;
	logic [14:0] flag_clear_ff;
	logic [7:0] in_service_ff;
	logic [7:0] nxt_in_service;
	logic nmi_sync1_ff;
	logic nmi_sync2_ff;
	logic nmi_prev_ff;
	logic nmi_pend_ff;
	logic wdt_pend_ff;
	logic [15:0] bank_w45_ff [NUM_BANKS];
	logic [15:0] bank_w67_ff [NUM_BANKS];

	logic [14:0] req_vec;
	logic [14:0] macro_mode;
	logic [14:0] eligible;
	logic [3:0] limit;
	logic found;
	logic [3:0] pick;
	logic [3:0] pick_lvl;
	logic [2:0] lvl;
	logic instr_evt;
	logic int_gate;
	logic take_nmi;
	logic take_irq;
	logic irq_macro;
	logic irq_ctx;
	logic ret_any;
	logic ctx_take;
	logic [2:0] ctx_bank;

	assign dispatch = dispatch_ff;
	assign flag_clear = flag_clear_ff;
	assign in_service = in_service_ff;

	// ==========================================================
	// nonmaskable pin: pin is asynchronous, two stages before use
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			nmi_sync1_ff <= 1'b0;
			nmi_sync2_ff <= 1'b0;
			nmi_prev_ff <= 1'b0;
		end else begin
			nmi_sync1_ff <= nmi_pin;
			nmi_sync2_ff <= nmi_sync1_ff;
			nmi_prev_ff <= nmi_sync2_ff;
		end
	end

	// pending nonmaskable events; a new event beats the clear
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			nmi_pend_ff <= 1'b0;
			wdt_pend_ff <= 1'b0;
		end else begin
			if (nmi_sync2_ff && !nmi_prev_ff) begin
				nmi_pend_ff <= 1'b1;
			end else if (take_nmi && nxt_dispatch.source == SRC_NMI) begin
				nmi_pend_ff <= 1'b0;
			end
			if (watchdog_overflow_request) begin
				wdt_pend_ff <= 1'b1;
			end else if (take_nmi && nxt_dispatch.source == SRC_WDT) begin
				wdt_pend_ff <= 1'b0;
			end
		end
	end

	// ==========================================================
	// maskable sorting: lowest level wins, then lowest index
	always_comb begin
		req_vec = requests;
		limit = top_level(in_service_ff);
		found = 1'b0;
		pick = 4'h0;
		pick_lvl = LEVEL_IDLE;
		for (int i = 0; i < NUM_SRC; i++) begin
			macro_mode[i] = cfg.macro_enable[i] & MACRO_CAPABLE[i];
			// data moves do not enter service, so skip nesting check
			eligible[i] = req_vec[i] & ~cfg.mask[i] & (macro_mode[i] |
				(global_enable_state &
				({1'b0, src_level(cfg, i)} < limit)));
			// strict compare keeps the lower default index on ties
			if (eligible[i] && {1'b0, src_level(cfg, i)} < pick_lvl) begin
				found = 1'b1;
				pick = 4'(i);
				pick_lvl = {1'b0, src_level(cfg, i)};
			end
		end
	end

	// ==========================================================
	// acceptance order: instructions, then nonmaskable, then maskable
	assign lvl = pick_lvl[2:0];
	assign instr_evt = bank_switch_return | break_instruction |
		break_with_bank_switch;
	// one idle cycle after a dispatch lets the source drop its flag
	assign int_gate = !instr_evt && cpu_ready && !dispatch_ff.valid;
	assign take_nmi = int_gate && (nmi_pend_ff || wdt_pend_ff);
	assign take_irq = int_gate && !take_nmi && found;
	assign irq_macro = macro_mode[pick];
	assign irq_ctx = !irq_macro && cfg.bank_switch_enable[pick];
	assign ret_any = vectored_return | bank_switch_return;
	assign ctx_take = (take_irq && irq_ctx) ||
		(break_with_bank_switch && !bank_switch_return);
	assign ctx_bank = break_with_bank_switch ? break_bank : lvl;

	// ==========================================================
	// dispatch contents
	always_comb begin
		nxt_dispatch = '0;
		if (bank_switch_return) begin
			nxt_dispatch.valid = 1'b1;
			nxt_dispatch.kind = PIC_CS_RETURN;
			nxt_dispatch.source = SRC_RET;
			nxt_dispatch.bank = active_bank;
			nxt_dispatch.pc = bank_w45_ff[active_bank];
			nxt_dispatch.status_word = bank_w67_ff[active_bank];
		end else if (break_with_bank_switch) begin
			nxt_dispatch.valid = 1'b1;
			nxt_dispatch.kind = PIC_CONTEXT;
			nxt_dispatch.source = SRC_BREAK_WITH_BANK_SWITCH;
			nxt_dispatch.bank = break_bank;
			nxt_dispatch.pc = bank_w45_ff[break_bank];
		end else if (break_instruction) begin
			nxt_dispatch.valid = 1'b1;
			nxt_dispatch.kind = PIC_VECTORED;
			nxt_dispatch.source = SRC_BRK;
			nxt_dispatch.pc = VEC_BRK;
		end else if (take_nmi) begin
			// nonmaskable entries always stack, never switch banks
			nxt_dispatch.valid = 1'b1;
			nxt_dispatch.kind = PIC_VECTORED;
			if (wdt_pend_ff && (cfg.wdt_over_nmi || !nmi_pend_ff)) begin
				nxt_dispatch.source = SRC_WDT;
				nxt_dispatch.pc = VEC_WDT;
			end else begin
				nxt_dispatch.source = SRC_NMI;
				nxt_dispatch.pc = VEC_NMI;
			end
		end else if (take_irq) begin
			nxt_dispatch.valid = 1'b1;
			nxt_dispatch.source = {1'b0, pick};
			nxt_dispatch.maskable = 1'b1;
			nxt_dispatch.level = lvl;
			nxt_dispatch.bank = lvl;
			nxt_dispatch.two_byte = cfg.macro_two_byte[pick];
			if (irq_macro) begin
				// the move carries no counter or status
				nxt_dispatch.kind = PIC_MACRO;
				nxt_dispatch.pc = VEC_TABLE[pick];
			end else if (irq_ctx) begin
				nxt_dispatch.kind = PIC_CONTEXT;
				nxt_dispatch.pc = bank_w45_ff[lvl];
			end else begin
				nxt_dispatch.kind = PIC_VECTORED;
				nxt_dispatch.pc = VEC_TABLE[pick];
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			dispatch_ff <= '0;
		end else begin
			dispatch_ff <= nxt_dispatch;
		end
	end

	// acknowledge the chosen source so that it drops its flag
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			flag_clear_ff <= '0;
		end else begin
			flag_clear_ff <= '0;
			if (take_irq) begin
				flag_clear_ff[pick] <= 1'b1;
			end
		end
	end

	// ==========================================================
	// in-service levels: a return frees the highest, entry sets one
	always_comb begin
		nxt_in_service = in_service_ff;
		if (ret_any && limit != LEVEL_IDLE) begin
			nxt_in_service[limit[2:0]] = 1'b0;
		end
		if (take_irq && !irq_macro) begin
			nxt_in_service[lvl] = 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			in_service_ff <= '0;
		end else begin
			in_service_ff <= nxt_in_service;
		end
	end

	// ==========================================================
	// register banks: words four/five and six/seven of each bank
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int b = 0; b < NUM_BANKS; b++) begin
				bank_w45_ff[b] <= '0;
				bank_w67_ff[b] <= '0;
			end
		end else if (bank_switch_return) begin
			bank_w45_ff[active_bank] <= return_immediate;
		end else if (ctx_take) begin
			// swap: vector leaves, old counter and status go in
			bank_w45_ff[ctx_bank] <= cur_pc;
			bank_w67_ff[ctx_bank] <= cur_psw;
		end else if (bank_wr.valid) begin
			// software presets; loses to any hardware switch
			if (bank_wr.upper) begin
				bank_w67_ff[bank_wr.bank] <= bank_wr.data;
			end else begin
				bank_w45_ff[bank_wr.bank] <= bank_wr.data;
			end
		end
	end

	// ==========================================================
	// checks
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	break_vector_a: assert property (
		break_instruction && !bank_switch_return &&
		!break_with_bank_switch |=> dispatch_ff.valid &&
		dispatch_ff.kind == PIC_VECTORED && dispatch_ff.pc == VEC_BRK)
		else $error("break did not vector to its address");

	maskable_vector_a: assert property (
		dispatch_ff.valid && dispatch_ff.maskable &&
		dispatch_ff.kind == PIC_VECTORED |->
		dispatch_ff.pc == VEC_TABLE[dispatch_ff.source[3:0]])
		else $error("maskable vector does not match source");

	nest_refuse_a: assert property (
		dispatch_ff.valid && dispatch_ff.maskable &&
		dispatch_ff.kind != PIC_MACRO |->
		{1'b0, dispatch_ff.level} < top_level($past(in_service_ff)))
		else $error("request nested at equal or lower level");

	macro_source_a: assert property (
		dispatch_ff.valid && dispatch_ff.kind == PIC_MACRO |->
		MACRO_CAPABLE[dispatch_ff.source[3:0]] && dispatch_ff.maskable)
		else $error("data move from a source that lacks it");

	macro_state_a: assert property (
		take_irq && irq_macro && !ret_any |=>
		$stable(in_service_ff) && dispatch_ff.status_word == '0)
		else $error("data move disturbed service state");

	switch_enable_a: assert property (
		dispatch_ff.valid && dispatch_ff.kind == PIC_CONTEXT &&
		dispatch_ff.maskable |->
		$past(cfg.bank_switch_enable[nxt_dispatch.source[3:0]]) &&
		$past(global_enable_state))
		else $error("bank switch without enable");

	nmi_stack_a: assert property (
		dispatch_ff.valid && (dispatch_ff.source == SRC_NMI ||
		dispatch_ff.source == SRC_WDT) |->
		dispatch_ff.kind == PIC_VECTORED && !dispatch_ff.maskable)
		else $error("nonmaskable entry switched banks");

	return_store_a: assert property (
		bank_switch_return |=> dispatch_ff.kind == PIC_CS_RETURN ##0
		bank_w45_ff[$past(active_bank)] == $past(return_immediate))
		else $error("return immediate not stored in bank");

	service_set_a: assert property (
		dispatch_ff.valid && dispatch_ff.maskable &&
		dispatch_ff.kind != PIC_MACRO |-> in_service_ff[dispatch_ff.level])
		else $error("accepted level not marked in service");

	clear_pulse_a: assert property (
		dispatch_ff.valid && dispatch_ff.maskable |->
		flag_clear == (15'h0001 << dispatch_ff.source[3:0]))
		else $error("acknowledge does not match source");

endmodule

// *** pic_pkg.sv ***
// shared constants, types and carriers of the priority interrupt controller
package pic_pkg;

	// ==========================================================
	// sizes
	localparam int NUM_SRC = 15;
	localparam int NUM_GROUPS = 5;
	localparam int NUM_BANKS = 8;

	// ==========================================================
	// vector addresses
	localparam logic [15:0] VEC_RESET = 16'h0000;
	localparam logic [15:0] VEC_NMI = 16'h0002;
	localparam logic [15:0] VEC_WDT = 16'h000a;
	localparam logic [15:0] VEC_BRK = 16'h003e;
	// maskable vectors, index is the default priority
	localparam logic [15:0] VEC_TABLE [NUM_SRC] = '{
		16'h001a, 16'h001c, 16'h001e, 16'h0020,
		16'h0004, 16'h0006, 16'h0008,
		16'h000e, 16'h0010, 16'h0012,
		16'h0022, 16'h0024, 16'h0026,
		16'h0028, 16'h000c};
	// group of each maskable source
	localparam logic [2:0] GROUP_OF [NUM_SRC] = '{
		3'h0, 3'h0, 3'h0, 3'h0, 3'h1, 3'h1, 3'h1,
		3'h2, 3'h2, 3'h2, 3'h3, 3'h3, 3'h3, 3'h4, 3'h4};
	// sources that may be served by a data move
	localparam logic [14:0] MACRO_CAPABLE = 15'h3bf5;

	// ==========================================================
	// source codes reported with a dispatch
	localparam logic [4:0] SRC_NMI = 5'h0f;
	localparam logic [4:0] SRC_WDT = 5'h10;
	localparam logic [4:0] SRC_BRK = 5'h11;
	localparam logic [4:0] SRC_BREAK_WITH_BANK_SWITCH = 5'h12;
	localparam logic [4:0] SRC_RET = 5'h13;
	// level value meaning nothing in service
	localparam logic [3:0] LEVEL_IDLE = 4'h8;

	// ==========================================================
	// carriers
	typedef enum logic [2:0] {
		PIC_NONE = 3'b000,
		PIC_VECTORED = 3'b001,
		PIC_CONTEXT = 3'b010,
		PIC_MACRO = 3'b011,
		PIC_CS_RETURN = 3'b100
	} pic_kind_type;

	typedef struct packed {
		logic valid;
		pic_kind_type kind;
		logic [4:0] source;
		logic maskable;
		logic [2:0] level;
		logic [2:0] bank;
		logic two_byte;
		logic [15:0] pc;
		logic [15:0] status_word;
	} pic_dispatch_type;

	// first field is the top bit, so bit n is default priority n
	typedef struct packed {
		logic time_base_flag;
		logic conversion_done_flag;
		logic serial_transmit_flag;
		logic serial_receive_flag;
		logic serial_error_flag;
		logic timer_event2_flag;
		logic timer_event1_flag;
		logic timer_event0_flag;
		logic ext_pin2_flag;
		logic ext_pin1_flag;
		logic ext_pin0_flag;
		logic count1_compare_b_flag;
		logic count1_compare_a_flag;
		logic count0_compare_b_flag;
		logic count0_compare_a_flag;
	} pic_req_type;

	typedef struct packed {
		logic [14:0] mask;
		logic [14:0] bank_switch_enable;
		logic [14:0] macro_enable;
		logic [14:0] macro_two_byte;
		logic [NUM_GROUPS-1:0][2:0] group_level;
		logic wdt_over_nmi;
	} pic_cfg_type;

	typedef struct packed {
		logic valid;
		logic [2:0] bank;
		logic upper;
		logic [15:0] data;
	} pic_bank_wr_type;

endpackage

// *** pic_periph_model.sv ***
// peripheral request source model facing the interrupt controller
`timescale 1ns/10ps

// ==========================================================
// request flags held until the controller clears them
module pic_periph_model import pic_pkg::*; (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [14:0] raise,
	input wire logic [14:0] flag_clear,
	output pic_req_type requests
);
	pic_req_type req_ff;

	assign requests = req_ff;

	// a refused request keeps its flag up, so it simply waits its turn
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			req_ff <= '0;
		end else begin
			req_ff <= (req_ff & ~flag_clear) | raise;
		end
	end
endmodule

// *** pic_ctrl_test.sv ***
// self-checking testbench of the priority interrupt controller
`timescale 1ns/10ps

module pic_ctrl_test import pic_pkg::*;;
	logic core_clk, rst_n, ge, nmi, rdy;
	logic [4:0] evt;
	logic [2:0] bbank, abank;
	logic [15:0] cpc, cpsw, imm;
	logic [14:0] raise, fclr;
	logic [7:0] insvc;
	pic_cfg_type cfg;
	pic_req_type requests;
	pic_bank_wr_type bwr;
	pic_dispatch_type disp;
	int err_count, checked;
	logic [15:0] vtab [15] = '{16'h001a, 16'h001c, 16'h001e, 16'h0020,
		16'h0004, 16'h0006, 16'h0008, 16'h000e, 16'h0010, 16'h0012,
		16'h0022, 16'h0024, 16'h0026, 16'h0028, 16'h000c};

	// ==========================================================
	// design and request sources
	pic_ctrl u_pic_ctrl (.core_clk(core_clk), .rst_n(rst_n), .cfg(cfg),
		.requests(requests), .global_enable_state(ge), .nmi_pin(nmi),
		.watchdog_overflow_request(evt[4]), .cpu_ready(rdy),
		.cur_pc(cpc), .cur_psw(cpsw), .break_instruction(evt[0]),
		.break_with_bank_switch(evt[1]), .break_bank(bbank),
		.bank_switch_return(evt[2]), .active_bank(abank),
		.return_immediate(imm), .vectored_return(evt[3]), .bank_wr(bwr),
		.dispatch(disp), .flag_clear(fclr), .in_service(insvc));
	pic_periph_model u_pic_periph_model (.core_clk(core_clk),
		.rst_n(rst_n), .raise(raise), .flag_clear(fclr),
		.requests(requests));

	// 250 MHz core clock
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end

	// ==========================================================
	// shared helpers
	task automatic stop_test();
		$display("checked %0d errors %0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// bounded wait for the one-cycle dispatch pulse
	task automatic await();
		int n;
		for (n = 0; n < 40; n++) begin
			#1;
			if (disp.valid === 1'b1) return;
			@(posedge core_clk);
		end
		err_count++;
		$display("[ERR] %0t no dispatch", $time);
		stop_test();
	endtask

	task automatic expect_disp(input logic [2:0] k, input logic [15:0] pc,
		input logic [4:0] src);
		await();
		check(disp.kind, k);
		check(disp.pc, pc);
		check(disp.source, src);
	endtask

	// twelve cycles with no dispatch at all
	task automatic quiet();
		int n;
		int c;
		c = 0;
		for (n = 0; n < 12; n++) begin
			@(posedge core_clk);
			#1;
			if (disp.valid !== 1'b0) c++;
		end
		check(c, 0);
	endtask

	task automatic req(input logic [14:0] v);
		@(posedge core_clk);
		raise <= v;
		@(posedge core_clk);
		raise <= '0;
	endtask

	// one-cycle instruction or watchdog pulse
	task automatic ev(input logic [4:0] v);
		@(posedge core_clk);
		evt <= v;
		@(posedge core_clk);
		evt <= '0;
		#1;
	endtask

	// ==========================================================
	// scenarios
	task automatic run_vectors();
		int i;
		int g;
		@(posedge core_clk);
		cfg.group_level <= {3'h5, 3'h4, 3'h3, 3'h2, 3'h1};
		ge <= 1'b1;
		for (i = 0; i < 15; i++) begin
			g = i < 4 ? 0 : i < 7 ? 1 : i < 10 ? 2 : i < 13 ? 3 : 4;
			req(15'h1 << i);
			expect_disp(3'h1, vtab[i], 5'(i));
			check(fclr, 15'h1 << i);
			check(insvc, 8'h1 << (g + 1));
			ev(5'h08);
			check(insvc, 8'h0);
		end
	endtask

	task automatic run_nesting();
		@(posedge core_clk);
		cfg.group_level <= {3'h7, 3'h7, 3'h1, 3'h3, 3'h3};
		req(15'h0122);
		expect_disp(3'h1, 16'h0010, 5'h08);
		quiet();
		ev(5'h08);
		expect_disp(3'h1, 16'h001c, 5'h01);
		check(insvc, 8'h08);
		quiet();
		ev(5'h08);
		expect_disp(3'h1, 16'h0006, 5'h05);
		req(15'h0200);
		expect_disp(3'h1, 16'h0012, 5'h09);
		check(insvc, 8'h0a);
		ev(5'h08);
		check(insvc, 8'h08);
		ev(5'h08);
	endtask

	// bank switching enabled everywhere must not touch nonmaskable entry
	task automatic run_nonmaskable();
		@(posedge core_clk);
		cfg.bank_switch_enable <= '1;
		nmi <= 1'b1;
		expect_disp(3'h1, 16'h0002, 5'h0f);
		check(insvc, 8'h0);
		@(posedge core_clk);
		nmi <= 1'b0;
		ev(5'h10);
		expect_disp(3'h1, 16'h000a, 5'h10);
		ev(5'h01);
		expect_disp(3'h1, 16'h003e, 5'h11);
	endtask

	task automatic run_context();
		@(posedge core_clk);
		bwr <= '{1'b1, 3'h5, 1'b0, 16'h1234};
		cfg.bank_switch_enable <= 15'h0080;
		cfg.group_level <= {3'h7, 3'h7, 3'h5, 3'h7, 3'h7};
		ge <= 1'b0;
		abank <= 3'h5;
		imm <= 16'h4321;
		bbank <= 3'h6;
		@(posedge core_clk);
		bwr <= '{1'b1, 3'h6, 1'b0, 16'h0777};
		@(posedge core_clk);
		bwr <= '0;
		req(15'h0080);
		quiet();
		@(posedge core_clk);
		ge <= 1'b1;
		expect_disp(3'h2, 16'h1234, 5'h07);
		check(disp.bank, 3'h5);
		ev(5'h04);
		expect_disp(3'h4, 16'hbeef, 5'h13);
		check(disp.status_word, 16'h00a5);
		check(insvc, 8'h0);
		req(15'h0080);
		expect_disp(3'h2, 16'h4321, 5'h07);
		ev(5'h02);
		expect_disp(3'h2, 16'h0777, 5'h12);
		check(disp.bank, 3'h6);
		ev(5'h04);
		ev(5'h04);
	endtask

	// data moves ignore global enable and leave nesting state alone
	task automatic run_macro();
		logic [7:0] s;
		@(posedge core_clk);
		ge <= 1'b0;
		cfg.macro_enable <= 15'h6000;
		cfg.macro_two_byte <= 15'h2000;
		#1;
		s = insvc;
		req(15'h2000);
		expect_disp(3'h3, 16'h0028, 5'h0d);
		check(disp.two_byte, 1'b1);
		check(disp.status_word, 16'h0);
		check(insvc, s);
		req(15'h4000);
		quiet();
	endtask

	// ready low holds both nonmaskable requests; watchdog may outrank the pin
	task automatic run_gating();
		@(posedge core_clk);
		ge <= 1'b1;
		expect_disp(3'h1, 16'h000c, 5'h0e);
		check(disp.level, 3'h7);
		ev(5'h08);
		@(posedge core_clk);
		rdy <= 1'b0;
		cfg.wdt_over_nmi <= 1'b1;
		cfg.mask <= 15'h0001;
		nmi <= 1'b1;
		req(15'h0001);
		ev(5'h10);
		quiet();
		@(posedge core_clk);
		rdy <= 1'b1;
		expect_disp(3'h1, 16'h000a, 5'h10);
		@(posedge core_clk);
		expect_disp(3'h1, 16'h0002, 5'h0f);
		quiet();
		@(posedge core_clk);
		cfg.mask <= '0;
		nmi <= 1'b0;
		expect_disp(3'h1, 16'h001a, 5'h00);
		check(disp.maskable, 1'b1);
		ev(5'h08);
	endtask

	// ==========================================================
	// main sequence
	initial begin
		err_count = 0;
		checked = 0;
		rst_n = 1'b0;
		cfg = '0;
		ge = 1'b0;
		nmi = 1'b0;
		rdy = 1'b1;
		evt = '0;
		raise = '0;
		bbank = '0;
		abank = '0;
		cpc = 16'hbeef;
		cpsw = 16'h00a5;
		imm = '0;
		bwr = '0;
		repeat (20) @(posedge core_clk);
		rst_n <= 1'b1;
		#1;
		check(insvc, 8'h0);
		check(fclr, 15'h0);
		run_vectors();
		run_nesting();
		run_nonmaskable();
		run_context();
		run_macro();
		run_gating();
		stop_test();
	end
endmodule
